// ===== src/tsb_defs.svh
// Constants of the temperature sensor and battery monitor block.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef TSB_DEFS_SVH
`define TSB_DEFS_SVH
`define TSB_CLK_HZ        20000000
`define TSB_US_CYC        (`TSB_CLK_HZ / 1000000)
`define TSB_ADC_US        350
`define TSB_LBD_ON_US     250
`define TSB_LBD_PERIOD_S  1
`define TSB_LBD_PERIOD_US (`TSB_LBD_PERIOD_S * 1000000)
`define TSB_LBD_RUN       3'h4
// Register addresses
`define TSB_A_IS1     7'h03
`define TSB_A_IS2     7'h04
`define TSB_A_IE2     7'h06
`define TSB_A_OPCTL1  7'h07
`define TSB_A_ADCCFG  7'h0f
`define TSB_A_ADCVAL  7'h11
`define TSB_A_TSCTL   7'h12
`define TSB_A_TVOFF   7'h13
`define TSB_A_LBDT    7'h1a
`define TSB_A_VBAT    7'h1b
// Field positions
`define TSB_OP_ENLBD  6
`define TSB_IE2_LBD   2
`define TSB_IS2_LBD   2
`define TSB_ADC_START 7
`define TSB_TS_SHIFT  5
`define TSB_TS_TRIMEN 4
`define TSB_SEL_TEMP  3'h0
// Reset values
`define TSB_RST_ZERO  8'h00
`define TSB_RST_TSCTL 8'h20
`define TSB_RST_LBDT  8'h14
`endif

// ===== src/tsb_monitor.sv
// Temperature sensor readout and low battery monitor core.
// Assumes converter and battery codes arrive on the core clock.
`timescale 1ns/1ps
`include "tsb_defs.svh"
module tsb_monitor
    import tsb_pkg::*;
#(
    parameter int unsigned P_ADC_US        = `TSB_ADC_US,
    parameter int unsigned P_LBD_ON_US     = `TSB_LBD_ON_US,
    parameter int unsigned P_LBD_PERIOD_US = `TSB_LBD_PERIOD_US
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       spi_sdi_in,
    input  wire logic       spi_nsel_n_in,
    input  wire logic       sleep_mode_in,
    input  wire logic       atb_temp_sel_in,
    input  wire logic [7:0] conv_raw_in,
    input  wire logic [4:0] batt_code_in,
    output logic            spi_sdo_out,
    output logic            temp_sensor_on_out,
    output logic [1:0]      temp_range_out,
    output logic            temp_shift_en_out,
    output logic            temp_trim_en_out,
    output logic [3:0]      temp_trim_out,
    output logic [2:0]      conv_sel_out,
    output logic [1:0]      conv_ref_out,
    output logic            conv_run_out,
    output logic            batt_detector_on_out,
    output logic            rc_osc_on_out,
    output logic            interrupt_pin_n_out
);
    localparam logic [4:0] US_LAST = 5'(`TSB_US_CYC - 1);

    tsb_bus_t   bus;
    logic [7:0] rd_data;
    logic [4:0] us_cnt_r;
    logic       tick;
    logic [7:0] tsctl_r;
    logic [7:0] tvoff_r;
    logic [7:0] lbdt_r;
    logic [7:0] adccfg_r;
    logic [7:0] adcval_r;
    logic [7:0] opctl1_r;
    logic [7:0] ie2_r;
    logic [4:0] vbat_r;
    tsb_conv_t  conv_st_r;
    logic [8:0] conv_cnt_r;
    logic       conv_done;
    logic [19:0] per_cnt_r;
    logic       enlbd;
    logic       meas_done;
    logic       meet;
    logic [2:0] meet_cnt_r;
    logic       lbd_set;
    logic       lbd_clr;
    logic       lbd_flag_r;

    tsb_spi_port u_port (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .spi_sclk_in   (spi_sclk_in),
        .spi_sdi_in    (spi_sdi_in),
        .spi_nsel_n_in (spi_nsel_n_in),
        .rd_data_in    (rd_data),
        .spi_sdo_out   (spi_sdo_out),
        .bus_out       (bus)
    );

    // Free-running microsecond enable keeps the long timers narrow
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            us_cnt_r <= 5'h00;
        end else begin
            us_cnt_r <= (us_cnt_r == US_LAST) ? 5'h00 : us_cnt_r + 5'h01;
        end
    end
    assign tick = (us_cnt_r == US_LAST);

    // Software-written configuration registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tsctl_r  <= `TSB_RST_TSCTL;
            tvoff_r  <= `TSB_RST_ZERO;
            lbdt_r   <= `TSB_RST_LBDT;
            opctl1_r <= `TSB_RST_ZERO;
            ie2_r    <= `TSB_RST_ZERO;
        end else if (bus.wr) begin
            if (bus.addr == `TSB_A_TSCTL) begin
                tsctl_r <= bus.wdata;
            end else if (bus.addr == `TSB_A_TVOFF) begin
                tvoff_r <= bus.wdata;
            end else if (bus.addr == `TSB_A_LBDT) begin
                lbdt_r <= {3'h0, bus.wdata[4:0]};
            end else if (bus.addr == `TSB_A_OPCTL1) begin
                opctl1_r <= bus.wdata;
            end else if (bus.addr == `TSB_A_IE2) begin
                ie2_r <= bus.wdata;
            end
        end
    end

    // Converter config; start bit is ignored while a conversion runs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            adccfg_r <= `TSB_RST_ZERO;
        end else if (bus.wr && bus.addr == `TSB_A_ADCCFG) begin
            adccfg_r <= {1'b0, bus.wdata[6:0]};
        end
    end

    assign conv_done = (conv_st_r == TSB_CONV_BUSY) && tick
                    && (conv_cnt_r == 9'(P_ADC_US - 1));

    // Conversion sequencer, counted in microseconds
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            conv_st_r  <= TSB_CONV_IDLE;
            conv_cnt_r <= 9'h000;
        end else begin
            case (conv_st_r)
                TSB_CONV_IDLE: begin
                    conv_cnt_r <= 9'h000;
                    if (bus.wr && bus.addr == `TSB_A_ADCCFG
                        && bus.wdata[`TSB_ADC_START]) begin
                        conv_st_r <= TSB_CONV_BUSY;
                    end
                end
                TSB_CONV_BUSY: begin
                    if (conv_done) begin
                        conv_st_r <= TSB_CONV_IDLE;
                    end else if (tick) begin
                        conv_cnt_r <= conv_cnt_r + 9'h001;
                    end
                end
                default: conv_st_r <= TSB_CONV_IDLE;
            endcase
        end
    end

    // Result; the offset wraps modulo 256, as an 8-bit register must
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            adcval_r <= `TSB_RST_ZERO;
        end else if (conv_done) begin
            adcval_r <= tsctl_r[`TSB_TS_SHIFT] ? 8'(conv_raw_in + tvoff_r)
                                               : conv_raw_in;
        end
    end

    // Analog controls for sensor and converter
    assign temp_sensor_on_out = (adccfg_r[6:4] == `TSB_SEL_TEMP)
                              || atb_temp_sel_in;
    assign temp_range_out     = tsctl_r[7:6];
    assign temp_shift_en_out  = tsctl_r[`TSB_TS_SHIFT];
    assign temp_trim_en_out   = tsctl_r[`TSB_TS_TRIMEN];
    assign temp_trim_out      = tsctl_r[3:0];
    assign conv_sel_out       = adccfg_r[6:4];
    assign conv_ref_out       = adccfg_r[3:2];
    assign conv_run_out       = (conv_st_r == TSB_CONV_BUSY);

    assign enlbd = opctl1_r[`TSB_OP_ENLBD];

    // Battery sampling period; a window opens at each period start
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enlbd) begin
            per_cnt_r <= 20'h00000;
        end else if (tick) begin
            per_cnt_r <= (per_cnt_r == 20'(P_LBD_PERIOD_US - 1))
                       ? 20'h00000 : per_cnt_r + 20'h00001;
        end
    end
    assign batt_detector_on_out = enlbd
                               && (per_cnt_r < 20'(P_LBD_ON_US));
    assign meas_done = enlbd && tick
                    && (per_cnt_r == 20'(P_LBD_ON_US - 1));
    assign rc_osc_on_out = enlbd && sleep_mode_in;

    // Code is latched at the end of the window, on the 50 mV scale
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            vbat_r <= 5'h00;
        end else if (meas_done) begin
            vbat_r <= batt_code_in;
        end
    end

    assign meet = batt_code_in < lbdt_r[4:0];

    // Run of consecutive low readings, saturating
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enlbd) begin
            meet_cnt_r <= 3'h0;
        end else if (meas_done) begin
            if (!meet) begin
                meet_cnt_r <= 3'h0;
            end else if (meet_cnt_r != `TSB_LBD_RUN) begin
                meet_cnt_r <= meet_cnt_r + 3'h1;
            end
        end
    end

    assign lbd_set = meas_done && meet
                  && (meet_cnt_r >= `TSB_LBD_RUN - 3'h1);
    assign lbd_clr = bus.rd && (bus.addr == `TSB_A_IS2);

    // Status flag clears on read; a new event wins over the clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lbd_flag_r <= 1'b0;
        end else if (lbd_set) begin
            lbd_flag_r <= 1'b1;
        end else if (lbd_clr) begin
            lbd_flag_r <= 1'b0;
        end
    end
    assign interrupt_pin_n_out = ~(lbd_flag_r & ie2_r[`TSB_IE2_LBD]);

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (bus.addr == `TSB_A_IS2) begin
            rd_data[`TSB_IS2_LBD] = lbd_flag_r;
        end else if (bus.addr == `TSB_A_IE2) begin
            rd_data = ie2_r;
        end else if (bus.addr == `TSB_A_OPCTL1) begin
            rd_data = opctl1_r;
        end else if (bus.addr == `TSB_A_ADCCFG) begin
            rd_data = {conv_run_out, adccfg_r[6:0]};
        end else if (bus.addr == `TSB_A_ADCVAL) begin
            rd_data = adcval_r;
        end else if (bus.addr == `TSB_A_TSCTL) begin
            rd_data = tsctl_r;
        end else if (bus.addr == `TSB_A_TVOFF) begin
            rd_data = tvoff_r;
        end else if (bus.addr == `TSB_A_LBDT) begin
            rd_data = lbdt_r;
        end else if (bus.addr == `TSB_A_VBAT) begin
            rd_data = enlbd ? {3'h0, vbat_r} : 8'h00;
        end
    end

    // Helper counters for timing checks; bounds follow the parameters
    localparam int ADC_CYC = P_ADC_US * `TSB_US_CYC;
    localparam int ON_CYC  = P_LBD_ON_US * `TSB_US_CYC;
    logic [15:0] busy_cyc_r;
    logic [15:0] on_cyc_r;
    always_ff @(posedge clk_in) begin
        busy_cyc_r <= conv_run_out ? busy_cyc_r + 16'h0001 : 16'h0000;
        on_cyc_r   <= batt_detector_on_out ? on_cyc_r + 16'h0001 : 16'h0000;
    end

    a_sensor_power: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        conv_run_out && conv_sel_out == 3'h0 |-> temp_sensor_on_out)
        else $error("sensor off while it is converted");
    a_conv_length: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(conv_run_out) |->
        busy_cyc_r >= ADC_CYC - 20 && busy_cyc_r <= ADC_CYC)
        else $error("conversion length wrong");
    a_offset_added: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        conv_done && temp_shift_en_out |=>
        adcval_r == 8'($past(conv_raw_in) + $past(tvoff_r)))
        else $error("offset not added to result");
    a_offset_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        conv_done && !temp_shift_en_out |=>
        adcval_r == $past(conv_raw_in))
        else $error("result shifted while shift disabled");
    a_reset_values: assert property (@(posedge clk_in)
        !rst_n_in |=> lbdt_r == 8'h14 && tsctl_r == 8'h20)
        else $error("wrong reset values");
    a_level_upper: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        bus.addr == `TSB_A_VBAT |-> rd_data[7:5] == 3'h0
        && (enlbd || rd_data == 8'h00))
        else $error("battery level upper bits set");
    a_four_runs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(lbd_flag_r) |->
        $past(meet_cnt_r) >= 3'h3 && $past(meas_done))
        else $error("flag raised before four readings");
    a_window_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(batt_detector_on_out) && $past(enlbd) && enlbd |->
        on_cyc_r >= ON_CYC - 20 && on_cyc_r <= ON_CYC)
        else $error("detector window length wrong");
    a_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lbd_set && lbd_clr |=> lbd_flag_r)
        else $error("flag event lost on clear");
    a_pin_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        lbd_set && ie2_r[`TSB_IE2_LBD] |=> !interrupt_pin_n_out)
        else $error("interrupt pin not driven");
    a_rc_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sleep_mode_in && enlbd |-> rc_osc_on_out)
        else $error("oscillator not started in sleep");

    c_conv_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        conv_done);
    c_flag_rise: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(lbd_flag_r));
    c_pin_low: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        !interrupt_pin_n_out);
    c_set_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        lbd_set && lbd_clr);
endmodule : tsb_monitor

// ===== src/tsb_pkg.sv
// Types shared by the serial port and the monitor core.
// Assumes nothing beyond a SystemVerilog compiler.
package tsb_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } tsb_bus_t;

    typedef enum logic [0:0] {
        TSB_CONV_IDLE = 1'b0,
        TSB_CONV_BUSY = 1'b1
    } tsb_conv_t;
endpackage : tsb_pkg

// ===== src/tsb_spi_port.sv
// Serial register port: 16-bit frames, R/W bit, 7-bit address, data.
// Assumes SPI mode 0 and at least 5 core clocks per sclk half period.
`timescale 1ns/1ps
module tsb_spi_port
    import tsb_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       spi_sdi_in,
    input  wire logic       spi_nsel_n_in,
    input  wire logic [7:0] rd_data_in,
    output logic            spi_sdo_out,
    output tsb_bus_t        bus_out
);
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       sclk_d_r;
    logic [4:0] bit_cnt_r;
    logic [7:0] in_sh_r;
    logic [7:0] out_sh_r;
    logic       is_wr_r;
    logic [6:0] addr_r;
    logic       sclk;
    logic       sdi;
    logic       nsel_n;
    logic       rise;
    logic       fall;
    logic [7:0] in_nxt;

    assign sclk   = sync2_r[2];
    assign sdi    = sync2_r[1];
    assign nsel_n = sync2_r[0];
    assign rise   = sclk & ~sclk_d_r & ~nsel_n;
    assign fall   = ~sclk & sclk_d_r & ~nsel_n;
    assign in_nxt = {in_sh_r[6:0], sdi};

    // Two-stage pin synchronisers; select idles high
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1_r  <= 3'h1;
            sync2_r  <= 3'h1;
            sclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= {spi_sclk_in, spi_sdi_in, spi_nsel_n_in};
            sync2_r  <= sync1_r;
            sclk_d_r <= sync2_r[2];
        end
    end

    // Bit counter and command capture; bits past 16 are ignored
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || nsel_n) begin
            bit_cnt_r <= 5'h00;
            in_sh_r   <= 8'h00;
            is_wr_r   <= 1'b0;
            addr_r    <= 7'h00;
        end else if (rise && bit_cnt_r != 5'h10) begin
            in_sh_r   <= in_nxt;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h07) begin
                is_wr_r <= in_nxt[7];
                addr_r  <= in_nxt[6:0];
            end
        end
    end

    // One-cycle register strobes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bus_out <= '0;
        end else begin
            bus_out.wr <= 1'b0;
            bus_out.rd <= 1'b0;
            if (rise && bit_cnt_r == 5'h07 && !in_nxt[7]) begin
                bus_out.rd   <= 1'b1;
                bus_out.addr <= in_nxt[6:0];
            end else if (rise && bit_cnt_r == 5'h0f && is_wr_r) begin
                bus_out.wr    <= 1'b1;
                bus_out.addr  <= addr_r;
                bus_out.wdata <= in_nxt;
            end
        end
    end

    // Read data shifts out on falling edges after the first data bit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_sh_r <= 8'h00;
        end else if (bus_out.rd) begin
            out_sh_r <= rd_data_in;
        end else if (fall && bit_cnt_r >= 5'h09) begin
            out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
    end

    assign spi_sdo_out = out_sh_r[7];
endmodule : tsb_spi_port

// ===== verif/temp_sensor_and_low_battery_monitor_test.sv
// Self-checking bench for the temperature and battery monitor core.
// Assumes tsb_monitor with short battery periods and a host model.
`timescale 1ns/1ps
`include "tsb_defs.svh"
module temp_sensor_and_low_battery_monitor_test;
    import tsb_pkg::*;

    logic       clk_in;
    logic       rst_n_in;
    logic       sclk, sdi, nsel_n, sdo;
    logic       sleep_mode_in;
    logic       atb_temp_sel_in;
    logic [7:0] conv_raw_in;
    logic [4:0] batt_code_in;
    logic [1:0] temp_range_out;
    logic [3:0] temp_trim_out;
    logic [2:0] conv_sel_out;
    logic [1:0] conv_ref_out;
    logic       temp_sensor_on_out, temp_shift_en_out, temp_trim_en_out;
    logic       conv_run_out, batt_detector_on_out, rc_osc_on_out;
    logic       interrupt_pin_n_out;
    int         err_count;
    int         checks;

    // Short battery period so four readings fit in a few thousand clocks
    tsb_monitor #(.P_LBD_ON_US(5), .P_LBD_PERIOD_US(20)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk),
        .spi_sdi_in(sdi), .spi_nsel_n_in(nsel_n),
        .sleep_mode_in(sleep_mode_in), .atb_temp_sel_in(atb_temp_sel_in),
        .conv_raw_in(conv_raw_in), .batt_code_in(batt_code_in),
        .spi_sdo_out(sdo), .temp_sensor_on_out(temp_sensor_on_out),
        .temp_range_out(temp_range_out),
        .temp_shift_en_out(temp_shift_en_out),
        .temp_trim_en_out(temp_trim_en_out), .temp_trim_out(temp_trim_out),
        .conv_sel_out(conv_sel_out), .conv_ref_out(conv_ref_out),
        .conv_run_out(conv_run_out),
        .batt_detector_on_out(batt_detector_on_out),
        .rc_osc_on_out(rc_osc_on_out),
        .interrupt_pin_n_out(interrupt_pin_n_out));

    tsb_host_model host (.clk_in(clk_in), .sdo_in(sdo), .sclk_out(sclk),
                         .sdi_out(sdi), .nsel_n_out(nsel_n));

    // 20 MHz core clock
    always #25 clk_in = ~clk_in;

    // Compare an 8-bit result
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    // Compare a single pin
    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] x;
        host.xfer(1'b0, a, 8'h00, x);
        chk8(x, exp);
    endtask : rd_chk

    // Start a conversion, see it busy, wait past 350 us, read result
    task automatic conv(input logic [7:0] exp);
        wr(`TSB_A_ADCCFG, 8'h80);
        rd_chk(`TSB_A_ADCCFG, 8'h80);
        chk1(conv_run_out, 1'b1);
        repeat (7100) @(posedge clk_in);
        rd_chk(`TSB_A_ADCCFG, 8'h00);
        chk1(conv_run_out, 1'b0);
        rd_chk(`TSB_A_ADCVAL, exp);
    endtask : conv

    task automatic end_sim;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // Watchdog sized well above the expected 34k clocks of tests
    initial begin
        repeat (90000) @(posedge clk_in);
        err_count++;
        $display("FAIL t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end

    initial begin
        clk_in = 1'b0; rst_n_in = 1'b0; sleep_mode_in = 1'b0;
        atb_temp_sel_in = 1'b0; conv_raw_in = 8'h50; batt_code_in = 5'h0a;
        err_count = 0; checks = 0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        // Reset values and register access
        chk1(temp_shift_en_out, 1'b1);
        chk1(temp_sensor_on_out, 1'b1);
        chk1(interrupt_pin_n_out, 1'b1);
        rd_chk(`TSB_A_TSCTL, `TSB_RST_TSCTL);
        rd_chk(`TSB_A_TVOFF, 8'h00);
        rd_chk(`TSB_A_LBDT, `TSB_RST_LBDT);
        rd_chk(`TSB_A_VBAT, 8'h00);
        rd_chk(7'h7f, 8'h00);
        wr(`TSB_A_LBDT, 8'hff);
        rd_chk(`TSB_A_LBDT, 8'h1f);
        wr(`TSB_A_LBDT, 8'h14);
        $display("test reset_regs done");
        // Sensor power follows input select and test bus routing
        wr(`TSB_A_ADCCFG, 8'h10);
        chk1(temp_sensor_on_out, 1'b0);
        atb_temp_sel_in <= 1'b1;
        @(posedge clk_in);
        @(posedge clk_in);
        chk1(temp_sensor_on_out, 1'b1);
        atb_temp_sel_in <= 1'b0;
        wr(`TSB_A_ADCCFG, 8'h00);
        chk1(temp_sensor_on_out, 1'b1);
        // Every range code with shift enabled, then trim fields
        for (int r = 0; r < 4; r++) begin
            wr(`TSB_A_TSCTL, {r[1:0], 6'h20});
            chk8({6'h00, temp_range_out}, {6'h00, r[1:0]});
            rd_chk(`TSB_A_TSCTL, {r[1:0], 6'h20});
        end
        wr(`TSB_A_TSCTL, 8'h1b);
        chk8({3'h0, temp_shift_en_out, temp_trim_en_out, temp_trim_out},
             8'h1b);
        $display("test sensor_ctl done");
        // Digital offset added, wrapping, and absolute mode without it
        wr(`TSB_A_TVOFF, 8'h10);
        wr(`TSB_A_TSCTL, 8'h20);
        chk8({3'h0, conv_sel_out, conv_ref_out}, 8'h00);
        // Range 00 reading 60h means 96 x 0.5 - 64 = -16 C to the host
        conv(8'h60);
        wr(`TSB_A_TVOFF, 8'hf0);
        conv(8'h40);
        wr(`TSB_A_TSCTL, 8'h80);
        conv(8'h50);
        $display("test conversion done");
        // Battery: level below threshold for four readings pulls the pin low
        sleep_mode_in <= 1'b1;
        wr(`TSB_A_IE2, 8'h04);
        wr(`TSB_A_OPCTL1, 8'h40);
        repeat (10) @(posedge clk_in);
        chk1(rc_osc_on_out, 1'b1);
        chk1(batt_detector_on_out, 1'b1);
        repeat (100) @(posedge clk_in);
        chk1(batt_detector_on_out, 1'b0);
        repeat (940) @(posedge clk_in);
        chk1(interrupt_pin_n_out, 1'b1);
        rd_chk(`TSB_A_VBAT, 8'h0a);
        chk1(interrupt_pin_n_out, 1'b0);
        sleep_mode_in <= 1'b0;
        batt_code_in <= 5'h14;
        repeat (400) @(posedge clk_in);
        chk1(rc_osc_on_out, 1'b0);
        rd_chk(`TSB_A_IS1, 8'h00);
        rd_chk(`TSB_A_IS2, 8'h04);
        rd_chk(`TSB_A_IS2, 8'h00);
        chk1(interrupt_pin_n_out, 1'b1);
        wr(`TSB_A_OPCTL1, 8'h00);
        rd_chk(`TSB_A_VBAT, 8'h00);
        $display("test battery done");
        end_sim();
    end
endmodule : temp_sensor_and_low_battery_monitor_test

// ===== verif/tsb_host_model.sv
// Host microcontroller model: serial register port master, mode 0.
// Assumes the core clock is shared; frames run HALF clocks per sclk phase.
`timescale 1ns/1ps
module tsb_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clk_in,
    input  wire logic sdo_in,
    output logic      sclk_out,
    output logic      sdi_out,
    output logic      nsel_n_out
);
    // Idle lines before the first frame
    initial begin
        sclk_out   = 1'b0;
        sdi_out    = 1'b0;
        nsel_n_out = 1'b1;
    end

    // One 16-bit frame: direction bit, address, data, MSB first
    task automatic xfer(input  logic       wr,
                        input  logic [6:0] addr,
                        input  logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {wr, addr, wdata};
        rdata = 8'h00;
        @(posedge clk_in);
        nsel_n_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_out <= frame[i]; // Set while sclk low
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i < 8) begin
                rdata[i] = sdo_in; // Sampled as sclk rises
            end
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (HALF) @(posedge clk_in);
        nsel_n_out <= 1'b1;
        // Released data line shows the inverse so stale bits never match
        sdi_out <= ~frame[0];
        // Gap between frames keeps select high for more than 3 clocks
        repeat (4) @(posedge clk_in);
    endtask : xfer
endmodule : tsb_host_model
